// >>> design/mta_engine.sv
/*
  Indirect command engine for the MAC table with its AXI4-Lite register slave.
  Assumes a single 40 MHz clock, synchronous active-high reset, and an
  AXI4-Lite master that keeps to the usual valid/ready handshake.
*/
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mta_params.svh"
module mta_engine
  import mta_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Access-complete indication
  output var  logic        accessDoneIrq
);
  import mta_pkg::*;

  localparam logic [1:0] RespOk  = 2'h0;
  localparam logic [1:0] RespErr = 2'h2;

  // Table storage, index = row*4+col; the spare row sits after the hashed rows
  mta_entry_t table_r [`MTA_ENTRIES];

  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] keyHigh_r;
  logic [31:0] keyLow_r;
  mta_fields_t fields_r;
  logic [`MTA_ST_W-1:0] sticky_r;
  logic [31:0] scanCfg_r;
  logic [31:0] scanCfg1_r;
  logic [31:0] fidCtrl_r;
  logic [31:0] lastRow_r;
  logic [31:0] scanCnt_r;
  logic [31:0] posStat_r;
  logic [12:0] scanFid_r [`MTA_FID_VALS];
  mta_state_t  state_r;
  logic [`MTA_COL_W:0] col_r;
  logic        found_r;
  logic [`MTA_COL_W-1:0] hitCol_r;
  logic        freeSeen_r;
  logic [`MTA_COL_W-1:0] freeCol_r;
  logic        irq_r;

  // Write and read channel holding
  logic [11:0] awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        bValid_r;
  logic        arReady_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic        awReady_r;
  logic        wReady_r;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `MTA_OFS_SCAN_CNT + 12'h004) ||
             (a >= `MTA_OFS_FID_BASE && a <= `MTA_OFS_FID_END);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Staged key: address high bits beside the identifier, low bits alone
  wire logic [47:0] stageMac = {keyHigh_r[15:0], keyLow_r};
  wire logic [12:0] stageFid = keyHigh_r[28:16];
  wire mta_cmd_t    cmd      = mta_cmd_t'(ctrl_r[`MTA_CTRL_CMD_LSB +: 3]);
  wire logic        trigger  = ctrl_r[`MTA_CTRL_TRIG_BIT];
  wire logic [`MTA_ROW_W-1:0] dirRow  = ctrl_r[`MTA_CTRL_ROW_LSB +: `MTA_ROW_W];
  wire logic [`MTA_COL_W-1:0] dirCol  = ctrl_r[`MTA_CTRL_COL_LSB +: `MTA_COL_W];
  wire logic        dirSpare = ctrl_r[`MTA_CTRL_TYPE_BIT];

  // Fold of the key into a row; cheap but spreads adjacent keys
  wire logic [60:0] key = {stageFid, stageMac};
  logic [`MTA_ROW_W-1:0] hashFold;
  always_comb begin
    hashFold = '0;
    for (int i = 0; i < 61; i++) begin
      hashFold[i % `MTA_ROW_W] = hashFold[i % `MTA_ROW_W] ^ key[i];
    end
  end

  wire logic [`MTA_ROW_W-1:0] rowSel = (cmd == MTA_CMD_RDDIR) ? dirRow : hashFold;
  wire logic [`MTA_IDX_W-1:0] rowBase = dirSpare && cmd == MTA_CMD_RDDIR
                                        ? `MTA_IDX_W'(`MTA_ROWS * `MTA_COLS)
                                        : {1'b0, rowSel, 2'b00};
  wire logic [`MTA_IDX_W-1:0] curIdx  = rowBase + `MTA_IDX_W'(col_r[`MTA_COL_W-1:0]);
  wire mta_entry_t            curEnt  = table_r[curIdx];
  wire logic curMatch = curEnt.fields.valid && curEnt.mac == stageMac && curEnt.fid == stageFid;
  wire logic [`MTA_IDX_W-1:0] hitIdx  = rowBase + `MTA_IDX_W'(hitCol_r);
  wire logic [`MTA_IDX_W-1:0] freeIdx = rowBase + `MTA_IDX_W'(freeCol_r);
  wire mta_entry_t            hitEnt  = table_r[hitIdx];
  wire logic [`MTA_IDX_W-1:0] dirIdx  = rowBase + `MTA_IDX_W'(dirCol);

  // Bus decode
  wire logic wrGo = awHave_r && wHave_r && !bValid_r;
  wire logic [11:0] wrA = awAddr_r;
  wire logic [31:0] wrD = wData_r;
  wire logic wrCtrl    = wrGo && wrA == `MTA_OFS_CTRL;
  wire logic wrSticky  = wrGo && wrA == `MTA_OFS_STICKY;
  // Staging writes are honoured only while idle so a running command sees stable inputs
  wire logic stageOpen = !trigger;
  wire logic [3:0] fidSlot = wrA[5:2];

  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    case (s_axi_araddr)
      `MTA_OFS_CTRL:      rdMux = ctrl_r;
      `MTA_OFS_KEY_HIGH:  rdMux = keyHigh_r;
      `MTA_OFS_KEY_LOW:   rdMux = keyLow_r;
      `MTA_OFS_FIELDS:    rdMux = 32'(fields_r);
      `MTA_OFS_STICKY:    rdMux = 32'(sticky_r);
      `MTA_OFS_SCAN_CFG:  rdMux = scanCfg_r;
      `MTA_OFS_SCAN_CFG1: rdMux = scanCfg1_r;
      `MTA_OFS_FID_CTRL:  rdMux = fidCtrl_r;
      `MTA_OFS_LAST_ROW:  rdMux = lastRow_r;
      `MTA_OFS_SCAN_CNT:  rdMux = scanCnt_r;
      `MTA_OFS_POS_STAT:  rdMux = posStat_r;
      default: begin
        if (s_axi_araddr >= `MTA_OFS_FID_BASE && s_axi_araddr <= `MTA_OFS_FID_END) begin
          rdMux = 32'(scanFid_r[s_axi_araddr[5:2]]);
        end
      end
    endcase
  end

  // AXI4-Lite handshakes
  always_ff @(posedge clock) begin
    if (rst) begin
      awHave_r  <= 1'b0;
      wHave_r   <= 1'b0;
      awReady_r <= 1'b0;
      wReady_r  <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= '0;
      wStrb_r   <= '0;
      bValid_r  <= 1'b0;
      bResp_r   <= RespOk;
      arReady_r <= 1'b0;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RespOk;
    end else begin
      // Ready is registered; it mirrors the free state of the holding slot
      awReady_r <= wrGo || !(awHave_r || (s_axi_awvalid && awReady_r));
      wReady_r  <= wrGo || !(wHave_r || (s_axi_wvalid && wReady_r));
      if (s_axi_awvalid && awReady_r) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrGo) begin
        bValid_r <= 1'b1;
        bResp_r  <= mapped(wrA) ? RespOk : RespErr;
        awHave_r <= 1'b0;
        wHave_r  <= 1'b0;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
      arReady_r <= s_axi_arvalid && !arReady_r && !rValid_r;
      if (arReady_r) begin
        rValid_r <= 1'b1;
        rData_r  <= rdMux;
        rResp_r  <= mapped(s_axi_araddr) ? RespOk : RespErr;
      end else if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign accessDoneIrq = irq_r;

  // Plain configuration registers, writable only with byte strobes
  always_ff @(posedge clock) begin
    if (rst) begin
      scanCfg_r  <= `MTA_RST_ZERO;
      scanCfg1_r <= `MTA_RST_ZERO;
      fidCtrl_r  <= `MTA_RST_ZERO;
      lastRow_r  <= `MTA_RST_ZERO;
    end else if (wrGo) begin
      if (wrA == `MTA_OFS_SCAN_CFG)  scanCfg_r  <= merge(scanCfg_r, wrD, wStrb_r);
      if (wrA == `MTA_OFS_SCAN_CFG1) scanCfg1_r <= merge(scanCfg1_r, wrD, wStrb_r);
      if (wrA == `MTA_OFS_FID_CTRL)  fidCtrl_r  <= merge(fidCtrl_r, wrD, wStrb_r);
      if (wrA == `MTA_OFS_LAST_ROW)  lastRow_r  <= merge(lastRow_r, wrD, wStrb_r);
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MTA_FID_VALS; g++) begin : gFid
      always_ff @(posedge clock) begin
        if (rst) begin
          scanFid_r[g] <= '0;
        end else if (wrGo && wrA >= `MTA_OFS_FID_BASE && wrA <= `MTA_OFS_FID_END &&
                     fidSlot == 4'(g)) begin
          scanFid_r[g] <= wrD[12:0];
        end
      end
    end
  endgenerate

  // Command engine: walk the row column by column (not for a direct read), then apply the result
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r    <= MTA_IDLE;
      ctrl_r     <= `MTA_RST_ZERO;
      keyHigh_r  <= `MTA_RST_ZERO;
      keyLow_r   <= `MTA_RST_ZERO;
      fields_r   <= '0;
      sticky_r   <= '0;
      posStat_r  <= `MTA_RST_ZERO;
      scanCnt_r  <= `MTA_RST_ZERO;
      col_r      <= '0;
      found_r    <= 1'b0;
      hitCol_r   <= '0;
      freeSeen_r <= 1'b0;
      freeCol_r  <= '0;
      irq_r      <= 1'b0;
      for (int i = 0; i < `MTA_ENTRIES; i++) table_r[i] <= '0;
    end else begin
      irq_r <= 1'b0;
      // Software clears flags by writing ones; a flag set below still wins
      if (wrSticky) sticky_r <= sticky_r & ~wrD[`MTA_ST_W-1:0];
      if (wrGo && stageOpen) begin
        if (wrA == `MTA_OFS_CTRL)     ctrl_r    <= merge(ctrl_r, wrD, wStrb_r);
        if (wrA == `MTA_OFS_KEY_HIGH) keyHigh_r <= merge(keyHigh_r, wrD, wStrb_r);
        if (wrA == `MTA_OFS_KEY_LOW)  keyLow_r  <= merge(keyLow_r, wrD, wStrb_r);
        if (wrA == `MTA_OFS_FIELDS)   fields_r  <= mta_fields_t'(wrD[27:0]);
      end
      case (state_r)
        MTA_IDLE: begin
          col_r      <= '0;
          found_r    <= 1'b0;
          freeSeen_r <= 1'b0;
          if (trigger && !wrCtrl) state_r <= MTA_SEARCH;
        end
        MTA_SEARCH: begin
          scanCnt_r <= 32'(col_r);
          if (cmd == MTA_CMD_RDDIR) begin
            state_r <= MTA_APPLY;
          end else if (col_r == 3'(`MTA_COLS)) begin
            state_r <= MTA_APPLY;
          end else begin
            if (curMatch && !found_r) begin
              found_r  <= 1'b1;
              hitCol_r <= col_r[`MTA_COL_W-1:0];
            end
            if (!curEnt.fields.valid && !freeSeen_r) begin
              freeSeen_r <= 1'b1;
              freeCol_r  <= col_r[`MTA_COL_W-1:0];
            end
            col_r <= col_r + 3'h1;
          end
        end
        MTA_APPLY: begin
          state_r  <= MTA_IDLE;
          ctrl_r[`MTA_CTRL_TRIG_BIT] <= 1'b0;
          irq_r    <= 1'b1;
          posStat_r <= 32'(found_r ? hitIdx : (cmd == MTA_CMD_RDDIR ? dirIdx : freeIdx));
          case (cmd)
            MTA_CMD_LEARN: begin
              if (found_r && hitEnt.fields.addr != fields_r.addr) begin
                table_r[hitIdx].fields <= fields_r;
                sticky_r[`MTA_ST_MOVE] <= 1'b1;
              end else if (found_r) begin
                table_r[hitIdx].fields <= fields_r;
                sticky_r[`MTA_ST_REFRESH] <= 1'b1;
              end else if (freeSeen_r) begin
                table_r[freeIdx] <= '{fid: stageFid, mac: stageMac, fields: fields_r};
                sticky_r[`MTA_ST_INSERT] <= 1'b1;
              end else if (!table_r[rowBase + `MTA_IDX_W'(3)].fields.locked) begin
                // Full row: column 3 gives way, but only if it is not locked
                table_r[rowBase + `MTA_IDX_W'(3)] <= '{fid: stageFid, mac: stageMac,
                                                      fields: fields_r};
                sticky_r[`MTA_ST_REPLACE] <= 1'b1;
              end else if (fields_r.locked) begin
                sticky_r[`MTA_ST_REPL_FAIL] <= 1'b1;
              end else begin
                sticky_r[`MTA_ST_LRN_FAIL] <= 1'b1;
              end
            end
            MTA_CMD_FORGET: begin
              if (found_r) table_r[hitIdx].fields.valid <= 1'b0;
              sticky_r[found_r ? `MTA_ST_FORGET : `MTA_ST_FORG_FAIL] <= 1'b1;
            end
            MTA_CMD_LOOKUP: begin
              if (found_r) fields_r <= hitEnt.fields;
              sticky_r[found_r ? `MTA_ST_HIT : `MTA_ST_MISS] <= 1'b1;
            end
            MTA_CMD_RDDIR: begin
              keyHigh_r <= {3'h0, table_r[dirIdx].fid, table_r[dirIdx].mac[47:32]};
              keyLow_r  <= table_r[dirIdx].mac[31:0];
              fields_r  <= table_r[dirIdx].fields;
              sticky_r[`MTA_ST_RDDIR] <= 1'b1;
            end
            default: ;
          endcase
        end
        default: state_r <= MTA_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/mta_params.svh
/*
  Offsets, field positions, reset values and sizes for the table access engine.
  Assumes inclusion by the package and the engine; definitions only.
*/
`ifndef MTA_PARAMS_SVH
`define MTA_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define MTA_OFS_CTRL      12'h000
`define MTA_OFS_KEY_HIGH  12'h004
`define MTA_OFS_KEY_LOW   12'h008
`define MTA_OFS_FIELDS    12'h00c
`define MTA_OFS_STICKY    12'h010
`define MTA_OFS_SCAN_CFG  12'h014
`define MTA_OFS_SCAN_CFG1 12'h018
`define MTA_OFS_FID_CTRL  12'h01c
`define MTA_OFS_LAST_ROW  12'h020
`define MTA_OFS_SCAN_CNT  12'h024
`define MTA_OFS_POS_STAT  12'h028
`define MTA_OFS_FID_BASE  12'h040
`define MTA_OFS_FID_END   12'h07c

// Control register fields
`define MTA_CTRL_TRIG_BIT  0
`define MTA_CTRL_CMD_LSB   1
`define MTA_CTRL_COL_LSB   4
`define MTA_CTRL_TYPE_BIT  6
`define MTA_CTRL_ROW_LSB   8

// Table geometry: 8 rows of 4 columns plus a spare row
`define MTA_ROWS      8
`define MTA_ROW_W     3
`define MTA_COLS      4
`define MTA_COL_W     2
`define MTA_ENTRIES   36
`define MTA_IDX_W     6

// Sticky flag positions
`define MTA_ST_REFRESH   0
`define MTA_ST_INSERT    1
`define MTA_ST_REPLACE   2
`define MTA_ST_REPL_FAIL 3
`define MTA_ST_LRN_FAIL  4
`define MTA_ST_MOVE      5
`define MTA_ST_FORGET    6
`define MTA_ST_FORG_FAIL 7
`define MTA_ST_HIT       8
`define MTA_ST_MISS      9
`define MTA_ST_RDDIR     10
`define MTA_ST_W         11

`define MTA_FID_VALS     16
`define MTA_RST_ZERO     32'h0000_0000

`endif

// >>> design/mta_pkg.sv
/*
  Types shared by the table access engine.
  Assumes mta_params.svh alongside.
*/
`include "mta_params.svh"
package mta_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [1:0]  addrType;
    logic        srcKill;
    logic [2:0]  cpuQueue;
    logic        cpuCopy;
    logic        nxtLrnAll;
    logic        vlanIgnore;
    logic [1:0]  ageInterval;
    logic [1:0]  ageFlag;
    logic        mirror;
    logic        locked;
    logic        valid;
  } mta_fields_t;

  typedef struct packed {
    logic [12:0] fid;
    logic [47:0] mac;
    mta_fields_t fields;
  } mta_entry_t;

  typedef enum logic [2:0] {
    MTA_CMD_LEARN  = 3'h0,
    MTA_CMD_FORGET = 3'h1,
    MTA_CMD_LOOKUP = 3'h2,
    MTA_CMD_RDDIR  = 3'h3
  } mta_cmd_t;

  typedef enum logic [1:0] {
    MTA_IDLE   = 2'h0,
    MTA_SEARCH = 2'h1,
    MTA_APPLY  = 2'h2
  } mta_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        valid;
  } mta_req_t;
endpackage

// >>> test/mta_engine_props.sv
/*
  Concurrent checks on the table access engine ports.
  Assumes a bind onto mta_engine from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mta_params.svh"
module mta_engine_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Completion
  input wire logic        accessDoneIrq
);
  logic pend_r;
  wire  wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire  launch = wrBoth && s_axi_awaddr == `MTA_OFS_CTRL && s_axi_wdata[0];
  wire  rdTaken = s_axi_arvalid && s_axi_arready;
  // Holes in the map: between the status words and the scan slots, and past them
  wire  badAddr = (s_axi_araddr > `MTA_OFS_POS_STAT && s_axi_araddr < `MTA_OFS_FID_BASE)
                  || s_axi_araddr > `MTA_OFS_FID_END;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // A completion with no launch behind it would be a phantom command
  always_ff @(posedge clock) begin
    if (rst) pend_r <= 1'b0;
    else if (launch) pend_r <= 1'b1;
    else if (accessDoneIrq) pend_r <= 1'b0;
  end

  sequence ctrl_launch;
    launch;
  endsequence
  sequence done_soon;
    ##[2:15] accessDoneIrq;
  endsequence

  cmd_done_a: assert property (ctrl_launch |-> done_soon)
    else $error("command did not complete in time");
  irq_pulse_a: assert property (accessDoneIrq |=> !accessDoneIrq)
    else $error("completion pulse longer than one cycle");
  irq_cause_a: assert property (accessDoneIrq |-> pend_r)
    else $error("completion without a command");
  wr_answer_a: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read data missing");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  ar_wait_a: assert property ($rose(s_axi_arvalid) |-> ##[1:2] s_axi_arready)
    else $error("read address not taken");
  hole_err_a: assert property (rdTaken && badAddr |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  map_ok_a: assert property (rdTaken && !badAddr |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  reset_quiet_a: assert property ($fell(rst) |->
      !s_axi_bvalid && !s_axi_rvalid && !accessDoneIrq)
    else $error("outputs busy after reset");
endmodule
`default_nettype wire

// >>> test/test_mac_table_cpu_access.sv
/*
  Self-checking bench for the table access engine.
  Assumes the design package and header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mta_params.svh"
module test_mac_table_cpu_access;
  import mta_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} mta_row_t;
  logic        clock, rst, awV, wV, bRdy, arV, rRdy, awR, wR, bV, arR, rV, irq;
  logic [11:0] awA, arA;
  logic [31:0] wD, rD, rdData;
  logic [1:0]  bR, rR, rdResp, wrResp;
  logic [47:0] mac;
  logic [12:0] fid;
  logic [5:0]  pos;
  mta_fields_t f;
  logic [31:0] acc;
  logic [47:0] fills [6] = '{48'h9, 48'h12, 48'h24, 48'h1b, 48'h2d, 48'h2d};
  int          outs [6] = '{`MTA_ST_INSERT, `MTA_ST_INSERT, `MTA_ST_INSERT, `MTA_ST_REPLACE,
                            `MTA_ST_REPL_FAIL, `MTA_ST_LRN_FAIL};
  int          num_errors, tests_run, irqCount, irqBase;
  mta_row_t    rows [8] = '{
    '{`MTA_OFS_KEY_LOW, 32'hdead_beef, 32'hdead_beef, 2'h0},
    '{`MTA_OFS_KEY_HIGH, 32'h0abc_1234, 32'h0abc_1234, 2'h0},
    '{`MTA_OFS_FID_CTRL, 32'h0000_0001, 32'h0000_0001, 2'h0},
    '{`MTA_OFS_FID_BASE, 32'h0000_0123, 32'h0000_0123, 2'h0},
    '{`MTA_OFS_LAST_ROW, 32'h0000_0003, 32'h0000_0003, 2'h0},
    '{`MTA_OFS_SCAN_CFG, 32'h0000_00a5, 32'h0000_00a5, 2'h0},
    '{`MTA_OFS_SCAN_CFG1, 32'h0000_5a00, 32'h0000_5a00, 2'h0},
    '{12'h030, 32'h0000_0001, 32'h0000_0000, 2'h2}};

  mta_engine i_dut (.clock(clock), .rst(rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_bresp(bR), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
    .s_axi_rresp(rR), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .accessDoneIrq(irq));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) if (irq === 1'b1) irqCount <= irqCount + 1;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Handshakes are judged mid-cycle, which is what the next rising edge samples
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic awT, wT, bT;
    int n;
    @(posedge clock);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    bT = 1'b0;
    for (n = 0; n < 100 && !bT; n++) begin
      @(negedge clock);
      awT = awV && awR;
      wT = wV && wR;
      bT = bV;
      wrResp = bR;
      @(posedge clock);
      if (awT) awV <= 1'b0;
      if (wT) wV <= 1'b0;
      if (bT) bRdy <= 1'b0;
    end
    chk("write done", 32'h1, {31'h0, bT});
  endtask

  task automatic rd(input logic [11:0] a);
    logic arT, rT;
    int n;
    @(posedge clock);
    arA <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    rT = 1'b0;
    for (n = 0; n < 100 && !rT; n++) begin
      @(negedge clock);
      arT = arV && arR;
      rT = rV;
      rdData = rD;
      rdResp = rR;
      @(posedge clock);
      if (arT) arV <= 1'b0;
      if (rT) rRdy <= 1'b0;
    end
    chk("read done", 32'h1, {31'h0, rT});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, exp, rdData);
  endtask

  function automatic logic [31:0] cw(input mta_cmd_t c, input logic [5:0] p);
    return {21'h0, p[4:2], 1'b0, p[5], p[1:0], c, 1'b1};
  endfunction

  function automatic logic [31:0] bt(input int n);
    return 32'h1 << n;
  endfunction

  task automatic stage(input logic [47:0] m, input logic [12:0] i, input mta_fields_t e);
    wr(`MTA_OFS_KEY_HIGH, {3'h0, i, m[47:32]});
    wr(`MTA_OFS_KEY_LOW, m[31:0]);
    wr(`MTA_OFS_FIELDS, {4'h0, e});
  endtask

  // Polls the trigger instead of counting cycles: the search length depends on the command
  task automatic fin(input logic [31:0] sticky);
    int n;
    n = 0;
    do begin
      rd(`MTA_OFS_CTRL);
      n++;
    end while (rdData[0] !== 1'b0 && n < 30);
    chk("trigger", 32'h0, {31'h0, rdData[0]});
    chk("irq count", 32'(irqBase + 1), 32'(irqCount));
    rdc(`MTA_OFS_STICKY, sticky, "sticky");
  endtask

  task automatic cmd(input logic [31:0] c, input logic [31:0] sticky);
    irqBase = irqCount;
    wr(`MTA_OFS_CTRL, c);
    fin(sticky);
  endtask

  initial begin
    {rst, awV, wV, bRdy, arV, rRdy, awA, arA, wD} = '0;
    rst = 1'b1;
    num_errors = 0;
    tests_run = 0;
    irqCount = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc(`MTA_OFS_CTRL, 32'h0, "ctrl reset");
    rdc(`MTA_OFS_STICKY, 32'h0, "sticky reset");
    rdc(`MTA_OFS_POS_STAT, 32'h0, "pos reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", 32'(rows[i].r), 32'(wrResp));
      rdc(rows[i].a, rows[i].q, "reg readback");
      chk("rresp", 32'(rows[i].r), 32'(rdResp));
    end
    mac = 48'h0012_3456_789a;
    fid = 13'h0155;
    f = '0;
    f.valid = 1'b1;
    f.addr = 12'h123;
    stage(mac, fid, f);
    cmd(cw(MTA_CMD_LEARN, 6'h0), bt(`MTA_ST_INSERT));
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    cmd(cw(MTA_CMD_LEARN, 6'h0), bt(`MTA_ST_REFRESH));
    f.addr = 12'h045;
    wr(`MTA_OFS_FIELDS, {4'h0, f});
    cmd(cw(MTA_CMD_LEARN, 6'h0), bt(`MTA_ST_REFRESH) | bt(`MTA_ST_MOVE));
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    wr(`MTA_OFS_FIELDS, 32'h0);
    cmd(cw(MTA_CMD_LOOKUP, 6'h0), bt(`MTA_ST_HIT));
    rdc(`MTA_OFS_FIELDS, {4'h0, f}, "lookup fields");
    rd(`MTA_OFS_POS_STAT);
    pos = rdData[5:0];
    wr(`MTA_OFS_KEY_LOW, mac[31:0] ^ 32'h1);
    cmd(cw(MTA_CMD_LOOKUP, 6'h0), bt(`MTA_ST_HIT) | bt(`MTA_ST_MISS));
    stage(48'h0, 13'h0, '0);
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    cmd(cw(MTA_CMD_RDDIR, pos), bt(`MTA_ST_RDDIR));
    rdc(`MTA_OFS_KEY_HIGH, {3'h0, fid, mac[47:32]}, "direct high");
    rdc(`MTA_OFS_KEY_LOW, mac[31:0], "direct low");
    rdc(`MTA_OFS_FIELDS, {4'h0, f}, "direct fields");
    rdc(`MTA_OFS_POS_STAT, {26'h0, pos}, "position");
    stage(mac, fid, f);
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    cmd(cw(MTA_CMD_FORGET, 6'h0), bt(`MTA_ST_FORGET));
    cmd(cw(MTA_CMD_FORGET, 6'h0), bt(`MTA_ST_FORGET) | bt(`MTA_ST_FORG_FAIL));
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    cmd(cw(MTA_CMD_LOOKUP, 6'h0), bt(`MTA_ST_MISS));
    wr(`MTA_OFS_STICKY, 32'h0000_07ff);
    // Staging writes during a running command must not disturb it
    irqBase = irqCount;
    wr(`MTA_OFS_CTRL, cw(MTA_CMD_LEARN, 6'h0));
    wr(`MTA_OFS_KEY_LOW, 32'h0);
    fin(bt(`MTA_ST_INSERT));
    rdc(`MTA_OFS_KEY_LOW, mac[31:0], "busy write");
    rdc(`MTA_OFS_SCAN_CNT, `MTA_COLS, "scan count");
    // Keys whose fold agrees land in one row: fill it, then overflow it
    acc = bt(`MTA_ST_INSERT);
    for (int i = 0; i < 6; i++) begin
      f.locked = (i == 3 || i == 4);
      acc = acc | bt(outs[i]);
      stage(mac ^ fills[i], fid, f);
      cmd(cw(MTA_CMD_LEARN, 6'h0), acc);
    end
    cmd(cw(MTA_CMD_RDDIR, 6'h21), acc | bt(`MTA_ST_RDDIR));
    rdc(`MTA_OFS_POS_STAT, 32'h0000_0021, "spare position");
    rdc(`MTA_OFS_KEY_LOW, 32'h0, "spare entry");
    // Reset after the last command must drop the sticky flags and the staged fields
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc(`MTA_OFS_STICKY, 32'h0, "sticky after reset");
    rdc(`MTA_OFS_FIELDS, 32'h0, "fields after reset");
    conclude();
  end

  initial begin
    #500000;
    num_errors++;
    conclude();
  end
endmodule

bind mta_engine mta_engine_props i_props (.clock(clock), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .accessDoneIrq(accessDoneIrq));
`default_nettype wire
